// *** design/shift_sign_pkg.sv ***
package shift_sign_pkg;

  // ==========================================================
  // Widths
  localparam int ACC_W  = 48;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  localparam int HI_W   = ACC_W - DATA_W;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] OFS_A_LO   = 8'h00;
  localparam logic [7:0] OFS_A_HI   = 8'h04;
  localparam logic [7:0] OFS_B_LO   = 8'h08;
  localparam logic [7:0] OFS_B_HI   = 8'h0C;
  localparam logic [7:0] OFS_FLAGS  = 8'h10;
  localparam logic [7:0] OFS_CMD    = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;

  // ==========================================================
  // Field positions
  localparam int FLG_CARRY = 0;
  localparam int FLG_OVFL  = 1;
  localparam int FLG_SIGN  = 2;
  localparam int FLG_ZERO  = 3;
  localparam int CMD_SEL_B = 3;
  localparam int ST_BUSY    = 0;
  localparam int ST_STANDBY = 1;
  localparam int ST_WD_LO   = 2;
  localparam int ST_WD_HI   = 3;

  // ==========================================================
  // Reset values
  localparam logic [3:0] FLAGS_RST = 4'h0;
  localparam logic [1:0] WDOG_RST  = 2'h0;

  // ==========================================================
  // Watchdog-clear macro: bit 54 is index 0, bit 55 is index 1
  localparam int         WD_STEPS = 5;
  localparam logic [2:0] WD_LAST  = 3'h4;
  localparam logic [4:0] WD_IDX   = 5'h0A;  // Step k selects bit WD_IDX[k]
  localparam logic [4:0] WD_VAL   = 5'h0C;  // Step k writes WD_VAL[k]

  typedef enum logic [2:0] {
    OP_NONE  = 3'h0,
    OP_WDCLR = 3'h1,
    OP_SHL   = 3'h2,
    OP_SHR   = 3'h3,
    OP_SIGN  = 3'h4,
    OP_STOP  = 3'h5
  } op_e;

  function automatic logic is_zero(input logic [ACC_W-1:0] v);
    return (v == '0);
  endfunction

endpackage

// *** design/shift_sign_alu.sv ***
`timescale 1ns/10ps
module shift_sign_alu
  import shift_sign_pkg::*;
(
  input  wire op_e              op_i,
  input  wire logic [ACC_W-1:0] operand_i,
  input  wire logic [3:0]       flags_i,
  output logic      [ACC_W-1:0] result_o,
  output logic      [3:0]       flags_o
);

  wire [ACC_W-1:0] shl_val  = {operand_i[ACC_W-2:0], 1'b0};                  // RQ3
  wire [ACC_W-1:0] shr_val  = {operand_i[ACC_W-1], operand_i[ACC_W-1:1]};    // RQ4
  wire             old_sgn  = flags_i[FLG_SIGN];
  wire             op_neg   = operand_i[ACC_W-1] && !is_zero(operand_i);     // RQ7
  wire [ACC_W-1:0] neg_val  = ACC_W'(~operand_i + 1'b1);
  wire [ACC_W-1:0] sign_val = old_sgn ? neg_val : operand_i;                 // RQ6

  always_comb begin
    result_o = operand_i;
    flags_o  = flags_i;
    unique case (op_i)
      OP_SHL: begin
        result_o           = shl_val;
        flags_o[FLG_CARRY] = operand_i[ACC_W-1];                          // RQ3
        flags_o[FLG_SIGN]  = shl_val[ACC_W-1];
        flags_o[FLG_ZERO]  = is_zero(shl_val);
      end
      OP_SHR: begin
        result_o          = shr_val;
        flags_o[FLG_SIGN] = shr_val[ACC_W-1];
        flags_o[FLG_ZERO] = is_zero(shr_val);                             // RQ4
      end
      OP_SIGN: begin
        result_o          = sign_val;
        flags_o[FLG_SIGN] = op_neg;                                       // RQ5
        flags_o[FLG_ZERO] = is_zero(sign_val);
      end
      OP_NONE, OP_WDCLR, OP_STOP: begin
        result_o = operand_i;
        flags_o  = flags_i;                                               // RQ1
      end
      default: begin
        result_o = operand_i;
        flags_o  = flags_i;
      end
    endcase
  end

endmodule

// *** design/dsp_shift_sign_misc_ops.sv ***
`timescale 1ns/10ps
// What this block does
// RQ1: Watchdog clear restarts the watchdog, no operands, arithmetic flags untouched.
// RQ2: Watchdog clear runs five steps: clear 54, clear 55, set 54, set 55, clear 54.
// RQ3: Left shift by one, zero into bit 0, old top bit to carry, sign and zero.
// RQ4: Arithmetic right shift by one keeping top bit, updates sign and zero.
// RQ5: Sign op sets signum to operand's original sign and updates zero.
// RQ6: Sign op negates accumulator only when signum was one beforehand.
// RQ7: A zero operand counts as positive, clearing signum.
// RQ8: Stop halts clock, puts core and memory in standby until wake event.
module dsp_shift_sign_misc_ops
  import shift_sign_pkg::*;
(
  input  wire logic              CLK_I,
  input  wire logic              SRST_I,
  input  wire logic [ADDR_W-1:0] ADDR_I,
  input  wire logic [DATA_W-1:0] WDATA_I,
  input  wire logic              WR_I,
  input  wire logic              RD_I,
  input  wire logic              WAKE_I,
  output logic      [DATA_W-1:0] RDATA_O,
  output logic      [1:0]        WDOG_CTRL_O,
  output logic                   CLK_HALT_O,
  output logic                   STANDBY_O,
  output logic                   BUSY_O
);

  // ==========================================================
  // State
  logic [ACC_W-1:0]  acc_a_r;
  logic [ACC_W-1:0]  acc_b_r;
  logic [3:0]        flags_r;
  logic [1:0]        wdog_r;
  logic              busy_r;
  logic [2:0]        step_r;
  logic              standby_r;
  logic [DATA_W-1:0] rdata_r;
  logic [2:0]        wake_sync_r;
  logic              wake_lvl_r;

  // ==========================================================
  // Decode
  wire        wr_a_lo   = WR_I && ADDR_I == OFS_A_LO;
  wire        wr_a_hi   = WR_I && ADDR_I == OFS_A_HI;
  wire        wr_b_lo   = WR_I && ADDR_I == OFS_B_LO;
  wire        wr_b_hi   = WR_I && ADDR_I == OFS_B_HI;
  wire        wr_flags  = WR_I && ADDR_I == OFS_FLAGS;
  wire        wr_cmd    = WR_I && ADDR_I == OFS_CMD;
  // Commands only land while idle and awake; busy or asleep drops them
  wire        accept    = wr_cmd && !busy_r && !standby_r;
  wire op_e   cmd_op    = op_e'(WDATA_I[2:0]);
  wire        cmd_sel_b = WDATA_I[CMD_SEL_B];
  wire op_e   alu_op    = accept ? cmd_op : OP_NONE;
  wire [ACC_W-1:0] operand = cmd_sel_b ? acc_b_r : acc_a_r;
  wire [ACC_W-1:0] alu_res;
  wire [3:0]       alu_flags;
  wire        do_alu    = accept && (cmd_op == OP_SHL || cmd_op == OP_SHR
                                     || cmd_op == OP_SIGN);
  wire        start_wd  = accept && cmd_op == OP_WDCLR;
  wire        start_stop = accept && cmd_op == OP_STOP;

  // Stable level once second and third stage agree
  wire        wake_stable = wake_sync_r[1] == wake_sync_r[2];
  wire        wake_lvl_nxt = wake_stable ? wake_sync_r[2] : wake_lvl_r;
  wire        wake_rise = wake_lvl_nxt && !wake_lvl_r;

  wire [DATA_W-1:0] status_word = {{(DATA_W-4){1'b0}}, wdog_r, standby_r, busy_r};
  logic [DATA_W-1:0] rdata_nxt;

  always_comb begin
    rdata_nxt = '0;
    unique case (ADDR_I)
      OFS_A_LO:   rdata_nxt = acc_a_r[DATA_W-1:0];
      OFS_A_HI:   rdata_nxt = {{(DATA_W-HI_W){1'b0}}, acc_a_r[ACC_W-1:DATA_W]};
      OFS_B_LO:   rdata_nxt = acc_b_r[DATA_W-1:0];
      OFS_B_HI:   rdata_nxt = {{(DATA_W-HI_W){1'b0}}, acc_b_r[ACC_W-1:DATA_W]};
      OFS_FLAGS:  rdata_nxt = {{(DATA_W-4){1'b0}}, flags_r};
      OFS_STATUS: rdata_nxt = status_word;
      default:    rdata_nxt = '0;
    endcase
  end

  shift_sign_alu u_alu (
    .op_i      (alu_op),
    .operand_i (operand),
    .flags_i   (flags_r),
    .result_o  (alu_res),
    .flags_o   (alu_flags)
  );

  // ==========================================================
  // Accumulators and flags, next values
  logic [ACC_W-1:0] acc_a_nxt;
  logic [ACC_W-1:0] acc_b_nxt;
  logic [3:0]       flags_nxt;

  // Bus writes first; an ALU result in the same cycle overrides them
  always_comb begin
    acc_a_nxt = acc_a_r;
    if (wr_a_lo) begin
      acc_a_nxt[DATA_W-1:0] = WDATA_I;
    end
    if (wr_a_hi) begin
      acc_a_nxt[ACC_W-1:DATA_W] = WDATA_I[HI_W-1:0];
    end
    if (do_alu && !cmd_sel_b) begin
      acc_a_nxt = alu_res;
    end
  end

  always_comb begin
    acc_b_nxt = acc_b_r;
    if (wr_b_lo) begin
      acc_b_nxt[DATA_W-1:0] = WDATA_I;
    end
    if (wr_b_hi) begin
      acc_b_nxt[ACC_W-1:DATA_W] = WDATA_I[HI_W-1:0];
    end
    if (do_alu && cmd_sel_b) begin
      acc_b_nxt = alu_res;
    end
  end

  always_comb begin
    flags_nxt = flags_r;
    if (wr_flags) begin
      flags_nxt = WDATA_I[3:0];
    end
    if (do_alu) begin
      flags_nxt = alu_flags;                                              // RQ3 RQ4 RQ5
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      acc_a_r <= '0;
      acc_b_r <= '0;
      flags_r <= FLAGS_RST;
    end else begin
      acc_a_r <= acc_a_nxt;
      acc_b_r <= acc_b_nxt;
      flags_r <= flags_nxt;
    end
  end

  // ==========================================================
  // Watchdog-clear macro, one step per cycle, flags never touched
  logic [1:0] wdog_nxt;
  logic [2:0] step_nxt;
  logic       busy_nxt;

  // Step index picks which control bit moves and to which level
  always_comb begin
    wdog_nxt = wdog_r;
    step_nxt = step_r;
    busy_nxt = busy_r;
    if (start_wd) begin
      busy_nxt            = 1'b1;                                         // RQ1
      step_nxt            = 3'h1;
      wdog_nxt[WD_IDX[0]] = WD_VAL[0];                                    // RQ2
    end else if (busy_r) begin
      wdog_nxt[WD_IDX[step_r]] = WD_VAL[step_r];                          // RQ2
      step_nxt                 = 3'(step_r + 3'h1);
      if (step_r == WD_LAST) begin
        busy_nxt = 1'b0;
      end
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      busy_r <= 1'b0;
      step_r <= '0;
      wdog_r <= WDOG_RST;
    end else begin
      busy_r <= busy_nxt;
      step_r <= step_nxt;
      wdog_r <= wdog_nxt;
    end
  end

  // ==========================================================
  // Stop and wake
  logic standby_nxt;

  // A wake already high when stop lands is ignored; only a new edge wakes
  always_comb begin
    standby_nxt = standby_r;
    if (start_stop) begin
      standby_nxt = 1'b1;                                                 // RQ8
    end else if (wake_rise) begin
      standby_nxt = 1'b0;                                                 // RQ8
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      wake_sync_r <= '0;
      wake_lvl_r  <= 1'b0;
      standby_r   <= 1'b0;
    end else begin
      wake_sync_r <= {wake_sync_r[1:0], WAKE_I};
      wake_lvl_r  <= wake_lvl_nxt;
      standby_r   <= standby_nxt;
    end
  end

  // ==========================================================
  // Outputs
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= RD_I ? rdata_nxt : '0;
    end
  end

  assign RDATA_O     = rdata_r;
  assign WDOG_CTRL_O = wdog_r;
  assign CLK_HALT_O  = standby_r;
  assign STANDBY_O   = standby_r;
  assign BUSY_O      = busy_r;

endmodule

// *** testbench/shift_sign_properties.sv ***
`timescale 1ns/10ps
module shift_sign_checker
  import shift_sign_pkg::*;
(
  input wire logic        CLK_I,
  input wire logic        SRST_I,
  input wire logic [7:0]  ADDR_I,
  input wire logic [31:0] WDATA_I,
  input wire logic        WR_I,
  input wire logic        RD_I,
  input wire logic        WAKE_I,
  input wire logic [31:0] RDATA_O,
  input wire logic [1:0]  WDOG_CTRL_O,
  input wire logic        CLK_HALT_O,
  input wire logic        STANDBY_O,
  input wire logic        BUSY_O
);
  // ==========================================
  // Command acceptance and timing checks
  default clocking @(posedge CLK_I); endclocking
  default disable iff (SRST_I);
  // Busy or standby drops the command silently
  wire cmd_ok = WR_I && ADDR_I == OFS_CMD && !BUSY_O && !STANDBY_O;
  a_wd_order: assert property (cmd_ok && WDATA_I[2:0] == 3'h1 |=> BUSY_O
    && WDOG_CTRL_O == 2'h0 ##1 WDOG_CTRL_O == 2'h0 ##1 WDOG_CTRL_O == 2'h1
    ##1 WDOG_CTRL_O == 2'h3 ##1 WDOG_CTRL_O == 2'h2 && !BUSY_O) else $error("wd order");
  a_wd_length: assert property ($rose(BUSY_O) |-> BUSY_O[*4] ##1 !BUSY_O)
    else $error("busy length");
  a_wd_quiet: assert property ($changed(WDOG_CTRL_O) && !$past(SRST_I)
    |-> $past(BUSY_O) || BUSY_O) else $error("wd moved idle");
  a_busy_awake: assert property (BUSY_O |-> !STANDBY_O) else $error("busy in standby");
  a_stop_halt: assert property (cmd_ok && WDATA_I[2:0] == 3'h5 |=> STANDBY_O)
    else $error("stop ignored");
  a_halt_stby: assert property (CLK_HALT_O == STANDBY_O) else $error("halt mismatch");
  a_stby_hold: assert property ((STANDBY_O && !WAKE_I)[*8] |=> STANDBY_O)
    else $error("standby lost");
  a_wake_soon: assert property (STANDBY_O && !WAKE_I ##1 (WAKE_I && !WR_I)[*8]
    |-> !STANDBY_O) else $error("no wake");
endmodule
bind dsp_shift_sign_misc_ops shift_sign_checker chk (.CLK_I(CLK_I), .SRST_I(SRST_I),
  .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .WAKE_I(WAKE_I),
  .RDATA_O(RDATA_O), .WDOG_CTRL_O(WDOG_CTRL_O), .CLK_HALT_O(CLK_HALT_O),
  .STANDBY_O(STANDBY_O), .BUSY_O(BUSY_O));

// *** testbench/tb.sv ***
`timescale 1ns/10ps
module tb
  import shift_sign_pkg::*;
;
  logic        clk = 0, srst = 1, wr = 0, rd = 0, wake = 0, halt, stby, busy, rd_q = 0;
  logic [7:0]  addr = '0;
  logic [31:0] wdata = '0, rdata;
  logic [1:0]  wdog;
  logic [31:0] exp_q[$];
  int          error_cnt = 0, total_checks = 0, cyc = 0;
  integer      seed = 32'h072C;
  dsp_shift_sign_misc_ops uut (.CLK_I(clk), .SRST_I(srst), .ADDR_I(addr), .WDATA_I(wdata),
    .WR_I(wr), .RD_I(rd), .WAKE_I(wake), .RDATA_O(rdata), .WDOG_CTRL_O(wdog),
    .CLK_HALT_O(halt), .STANDBY_O(stby), .BUSY_O(busy));
  initial forever #12.5 clk = ~clk;
  // ==========================================
  // Bus master, reads queue their expectation
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {wr, rd} <= {w, !w};
    addr     <= a;
    wdata    <= w ? d : 32'h0;
    if (!w) exp_q.push_back(d);
    @(posedge clk);
    {wr, rd} <= 2'b00;
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // ==========================================
  // Read data monitor and hang guard
  always @(posedge clk) begin
    rd_q <= rd;
    cyc  <= cyc + 1;
    if (cyc == 2000) begin // Whole run needs about 475 cycles
      error_cnt++;
      finish_test();
    end
  end
  // Negedge sampling keeps clear of the register update race
  always @(negedge clk) begin
    if (rd_q) begin
      total_checks++;
      error_cnt += int'(rdata !== exp_q[0]);
      if (rdata !== exp_q[0]) $display("CHECK FAILED rdata exp %h got %h", exp_q[0], rdata);
      exp_q.delete(0);
    end
  end
  // ==========================================
  // Stimulus
  initial begin
    logic [47:0] v, r;
    logic [3:0]  f, n;
    logic [2:0]  op;
    logic [7:0]  b;
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    for (int i = 0; i < 30; i++) begin
      op = 3'(2 + i % 3);
      b  = (i % 2) ? OFS_B_LO : OFS_A_LO;
      // Zero and most negative first, then random
      v  = (i < 3) ? 48'h0 : (i < 6) ? 48'h8000_0000_0000 : 48'({$random(seed), $random(seed)});
      f  = 4'($random(seed));
      bus(1'b1, b, v[31:0]);
      bus(1'b1, b + 8'h04, {16'h0, v[47:32]});
      bus(1'b1, OFS_FLAGS, {28'h0, f});
      bus(1'b1, OFS_CMD, {28'h0, b[3], op});
      r = (op == 3'h2) ? v << 1 : (op == 3'h3) ? {v[47], v[47:1]} : f[2] ? -v : v;
      n = {(r == 48'h0), (op == 3'h4) ? v[47] : r[47], f[1], (op == 3'h2) ? v[47] : f[0]};
      bus(1'b0, b, r[31:0]);
      bus(1'b0, b + 8'h04, {16'h0, r[47:32]});
      bus(1'b0, OFS_FLAGS, {28'h0, n});
    end
    $display("shift and sign test done");
    bus(1'b0, 8'hFC, 32'h0);
    bus(1'b1, OFS_FLAGS, 32'hB);
    bus(1'b1, OFS_CMD, 32'h1);
    repeat (6) @(posedge clk);
    bus(1'b0, OFS_STATUS, 32'h8);
    bus(1'b0, OFS_FLAGS, 32'hB);
    $display("watchdog test done");
    bus(1'b1, OFS_CMD, 32'h5);
    repeat (10) @(posedge clk);
    bus(1'b0, OFS_STATUS, 32'hA);
    wake <= 1'b1;
    repeat (10) @(posedge clk);
    bus(1'b0, OFS_STATUS, 32'h8);
    repeat (2) @(posedge clk);
    $display("stop test done");
    finish_test();
  end
endmodule
